// ### include/oss_pkg.sv
// constants for the oscillator source select block
// assumes one system clock; oscillator edges arrive as enable pulses
package oss_pkg;
    // ****************************************************************
    // group codes
    // ****************************************************************
    localparam logic [2:0] OSS_GRP_PLL = 3'h7;
    localparam logic [2:0] OSS_GRP_EXT = 3'h3;
    localparam logic [2:0] OSS_GRP_WATCH = 3'h0;
    localparam logic [2:0] OSS_GRP_FRC = 3'h1;
    localparam logic [2:0] OSS_GRP_LOW_POWER_RC = 3'h2;
    // ****************************************************************
    // primary codes
    // ****************************************************************
    localparam logic [4:0] OSS_PR_LFXT = 5'h00;
    localparam logic [4:0] OSS_PR_HSXT = 5'h02;
    localparam logic [4:0] OSS_PR_MIDXT = 5'h04;
    localparam logic [4:0] OSS_PR_EXT_RC_IO = 5'h08;
    localparam logic [4:0] OSS_PR_ERC = 5'h09;
    localparam logic [4:0] OSS_PR_EC = 5'h0B;
    localparam logic [4:0] OSS_PR_EXT_CLOCK_IO = 5'h0C;
    localparam logic [4:0] OSS_PR_FRC4 = 5'h01;
    localparam logic [4:0] OSS_PR_FRC8 = 5'h0A;
    localparam logic [4:0] OSS_PR_FRC16 = 5'h03;
    // ****************************************************************
    // start-up timer and field positions
    // ****************************************************************
    localparam int OSS_OST_W = 10;
    localparam int OSS_OST_CYCLES = 1024;
    localparam int OSS_CUR_LSB = 12;
    localparam int OSS_CUR_MSB = 14;
    localparam logic [15:0] OSS_STAT_RESET = 16'h0000;
    // ****************************************************************
    // decoded mode enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        OSS_MUL_NONE = 2'h0,
        OSS_MUL_X4 = 2'h1,
        OSS_MUL_X8 = 2'h2,
        OSS_MUL_X16 = 2'h3
    } oss_mul_e;
    typedef enum logic [1:0] {
        OSS_PIN_XTAL = 2'h0,
        OSS_PIN_CLOCK_OUTPUT = 2'h1,
        OSS_PIN_GPIO = 2'h2
    } oss_pin_e;
    typedef enum logic [3:0] {
        OSS_ST_RESET = 4'h1,
        OSS_ST_WAIT = 4'h2,
        OSS_ST_LOCK = 4'h4,
        OSS_ST_RUN = 4'h8
    } oss_state_e;
endpackage : oss_pkg

// ### logic/oss_source_select.sv
// oscillator source select: decodes fuses, gates the system clock
// assumes fuse inputs are stable while resetn_i is low and after
// Function
// - pick source from group and primary fields
// - 1024-cycle start timer withholds oscillator clock
// - start timer only for crystal modes
// - group field picks one of five groups
// - decode external primary modes
// - decode PLL primary modes and multipliers
// - second pin role follows primary mode
// - first pin never general I/O
// - watch crystal runs while enable set
// - watch crystal clocks system on 000 while enable set
// - PLL gain four, eight or sixteen
// - lock indication mirrored in status bit
// - tune field offsets fast RC
// - low-power RC on at power-on
// - low-power RC kept alive by monitor/watchdog/select
// - current group readable at bits 14:12
// - current and new group loaded on the first clock after reset release
`timescale 1ns/100ps
`default_nettype none
module oss_source_select
    import oss_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [2:0] group_select_i,
    input wire logic [4:0] primary_select_i,
    input wire logic wake_i,
    input wire logic osc_tick_i,
    input wire logic pll_locked_i,
    input wire logic power_up_timer_expired_i,
    input wire logic fail_safe_en_i,
    input wire logic watchdog_en_i,
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic [2:0] current_group_o,
    output logic [2:0] new_group_o,
    output logic [1:0] pll_mul_o,
    output logic pll_src_frc_o,
    output logic [1:0] pre_div_o,
    output logic ost_used_o,
    output logic clk_release_o,
    output logic [1:0] osc_out_role_o,
    output logic osc_in_is_gpio_o,
    output logic watch_osc_en_o,
    output logic watch_is_sysclk_o,
    output logic frc_en_o,
    output logic [3:0] frc_tune_o,
    output logic low_power_rc_en_o,
    output logic lock_o
);
    // ****************************************************************
    // register offsets (word index)
    // ****************************************************************
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_TUNE = 2'h1;
    localparam int LPOSC_BIT = 1;
    localparam int LOCK_BIT = 5;

    // ****************************************************************
    // decode functions
    // ****************************************************************
    // multiplier from a PLL-group primary code
    function automatic oss_mul_e mul_of(input logic [4:0] pr);
        oss_mul_e m;
        m = OSS_MUL_NONE;
        if (pr == OSS_PR_FRC4) begin
            m = OSS_MUL_X4;
        end else if (pr == OSS_PR_FRC8) begin
            m = OSS_MUL_X8;
        end else if (pr == OSS_PR_FRC16) begin
            m = OSS_MUL_X16;
        end else if (pr[1:0] != 2'h0 &&
                     pr[4:2] inside {3'h1, 3'h3, 3'h4, 3'h5}) begin
            m = oss_mul_e'(pr[1:0]);
        end
        return m;
    endfunction : mul_of

    // role of the second pin from the primary code
    function automatic oss_pin_e pin_of(input logic [4:0] pr);
        oss_pin_e p;
        p = OSS_PIN_XTAL;
        if (pr == OSS_PR_EC || pr == OSS_PR_ERC) begin
            p = OSS_PIN_CLOCK_OUTPUT;
        end else if (pr == OSS_PR_EXT_CLOCK_IO || pr == OSS_PR_EXT_RC_IO ||
                     pr[4:2] == 3'h3 || pr == OSS_PR_FRC4 ||
                     pr == OSS_PR_FRC8 || pr == OSS_PR_FRC16) begin
            p = OSS_PIN_GPIO;
        end
        return p;
    endfunction : pin_of

    // crystal modes need the start-up timer
    function automatic logic xtal_of(input logic [2:0] g,
                                     input logic [4:0] pr);
        logic x;
        x = 1'b0;
        if (g == OSS_GRP_WATCH) begin
            x = 1'b1;
        end else if (g == OSS_GRP_EXT) begin
            x = pr == OSS_PR_LFXT || pr == OSS_PR_HSXT ||
                pr == OSS_PR_MIDXT;
        end else if (g == OSS_GRP_PLL) begin
            x = pr[4] || pr[4:2] == 3'h1;
        end
        return x;
    endfunction : xtal_of

    // ****************************************************************
    // fuse capture
    // ****************************************************************
    logic [2:0] cur_q;
    logic [2:0] new_q;
    logic [4:0] pr_q;
    logic cap_q;
    logic lposc_q;
    logic [3:0] tune_q;
    logic low_power_rc_q;
    logic lock_q;
    logic ost_start;
    logic ost_done;
    oss_state_e st_q;

    // fuses caught on the first clock after release; held until reset
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cap_q <= 1'b0;
            cur_q <= 3'h0;
            pr_q <= 5'h00;
        end else if (!cap_q) begin
            cap_q <= 1'b1;
            cur_q <= group_select_i;
            pr_q <= primary_select_i;
        end
    end

    // new group loads with current; software may write it afterwards
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            new_q <= 3'h0;
        end else if (!cap_q) begin
            new_q <= group_select_i;
        end else if (wr_i && addr_i == REG_CTRL) begin
            new_q <= wdata_i[10:8];
        end
    end

    // software control bits
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lposc_q <= 1'b0;
            tune_q <= 4'h0;
        end else if (wr_i && addr_i == REG_CTRL) begin
            lposc_q <= wdata_i[LPOSC_BIT];
        end else if (wr_i && addr_i == REG_TUNE) begin
            tune_q <= wdata_i[3:0];
        end
    end

    // ****************************************************************
    // start-up sequence
    // ****************************************************************
    // a crystal restarts on reset release and on wake from sleep
    assign ost_start = (st_q == OSS_ST_RESET && cap_q) ||
                       (st_q == OSS_ST_RUN && wake_i &&
                        xtal_of(cur_q, pr_q));

    oss_startup_timer #(
        .CYCLES(OSS_OST_CYCLES)
    ) u_ost (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(ost_start),
        .osc_tick_i(osc_tick_i),
        .done_o(ost_done)
    );

    // state: reset -> wait start timer -> wait lock -> run
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= OSS_ST_RESET;
        end else begin
            unique case (st_q)
                OSS_ST_RESET: begin
                    if (cap_q) begin
                        st_q <= xtal_of(cur_q, pr_q) ? OSS_ST_WAIT
                                                     : OSS_ST_LOCK;
                    end
                end
                OSS_ST_WAIT: begin
                    if (ost_done) begin
                        st_q <= OSS_ST_LOCK;
                    end
                end
                OSS_ST_LOCK: begin
                    if (cur_q != OSS_GRP_PLL || pll_locked_i) begin
                        st_q <= OSS_ST_RUN;
                    end
                end
                OSS_ST_RUN: begin
                    if (ost_start) begin
                        st_q <= OSS_ST_WAIT;
                    end
                end
                default: st_q <= OSS_ST_RESET;
            endcase
        end
    end

    // ****************************************************************
    // lock and low-power RC
    // ****************************************************************
    // lock follows the loop both ways
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= pll_locked_i && cur_q == OSS_GRP_PLL;
        end
    end

    // on from reset since it clocks the power-up timer; the keep-alive
    // test waits for the fuse capture so a stale group cannot drop it
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_power_rc_q <= 1'b1;
        end else if (power_up_timer_expired_i && cap_q) begin
            low_power_rc_q <= fail_safe_en_i || watchdog_en_i ||
                      cur_q == OSS_GRP_LOW_POWER_RC;
        end
    end

    // ****************************************************************
    // decoded outputs
    // ****************************************************************
    assign current_group_o = cur_q;
    assign new_group_o = new_q;
    // multiplier only meaningful in the PLL group
    assign pll_mul_o = (cur_q == OSS_GRP_PLL) ? mul_of(pr_q)
                                              : OSS_MUL_NONE;
    assign pll_src_frc_o = cur_q == OSS_GRP_PLL &&
                           (pr_q == OSS_PR_FRC4 || pr_q == OSS_PR_FRC8 ||
                            pr_q == OSS_PR_FRC16);
    // 2 for the /2 crystal range, 3 for /3, else 1
    assign pre_div_o = (cur_q != OSS_GRP_PLL || !pr_q[4]) ? 2'h1 :
                       (pr_q[2] ? 2'h3 : 2'h2);
    assign ost_used_o = xtal_of(cur_q, pr_q);
    assign clk_release_o = st_q == OSS_ST_RUN;
    // pin role ignores the group on purpose
    assign osc_out_role_o = pin_of(pr_q);
    assign osc_in_is_gpio_o = 1'b0;
    assign watch_osc_en_o = lposc_q;
    assign watch_is_sysclk_o = cur_q == OSS_GRP_WATCH && lposc_q;
    assign frc_en_o = cur_q == OSS_GRP_FRC || pll_src_frc_o;
    assign frc_tune_o = tune_q;
    assign low_power_rc_en_o = low_power_rc_q;
    assign lock_o = lock_q;

    // ****************************************************************
    // register read port
    // ****************************************************************
    // data stands one cycle after the read strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= OSS_STAT_RESET;
        end else if (rd_i && addr_i == REG_CTRL) begin
            rdata_o <= {1'b0, cur_q, 1'b0, new_q, 2'h0, lock_q,
                        3'h0, lposc_q, 1'b0};
        end else if (rd_i && addr_i == REG_TUNE) begin
            rdata_o <= {12'h000, tune_q};
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence fuse_cap_s;
        !cap_q ##1 cap_q;
    endsequence
    grp_held_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cap_q |=> cur_q == $past(cur_q))
        else $error("group changed after capture");
    grp_load_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        fuse_cap_s |-> cur_q == $past(group_select_i))
        else $error("group not loaded from fuses");
    ost_wait_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        st_q == OSS_ST_WAIT && !ost_done |=> !clk_release_o)
        else $error("clock released before start timer");
    lock_follow_a: assert property (@(posedge clk_sys_i)
        disable iff (!resetn_i)
        cur_q == OSS_GRP_PLL |=> lock_o == $past(pll_locked_i))
        else $error("lock does not follow loop");
    low_power_rc_keep_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        power_up_timer_expired_i && watchdog_en_i |=> low_power_rc_en_o)
        else $error("low-power rc stopped with watchdog on");
    watch_sys_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        watch_is_sysclk_o |-> watch_osc_en_o && cur_q == 3'h0)
        else $error("watch crystal used while off");
    pin_in_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !osc_in_is_gpio_o)
        else $error("first pin given as io");
    frc_run_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cur_q == OSS_GRP_FRC |-> frc_en_o)
        else $error("fast rc off in its group");
    mul_x16_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cap_q && cur_q == 3'h7 && pr_q == 5'h03 |-> pll_mul_o == 2'h3)
        else $error("wrong multiplier");
endmodule : oss_source_select
`default_nettype wire

// ### logic/oss_startup_timer.sv
// oscillator start-up timer: counts oscillator edges before release
// assumes osc_tick_i is a one-cycle pulse per oscillator cycle
`timescale 1ns/100ps
`default_nettype none
module oss_startup_timer
    import oss_pkg::*;
#(
    parameter int CYCLES = OSS_OST_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic osc_tick_i,
    output logic done_o
);
    logic [OSS_OST_W-1:0] cnt_q;
    logic run_q;
    // 10-bit counter wraps after the last tick; done marks the wrap
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin
            cnt_q <= '0;
            run_q <= 1'b1;
            done_o <= 1'b0;
        end else if (run_q && osc_tick_i) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == OSS_OST_W'(CYCLES - 1)) begin
                run_q <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule : oss_startup_timer
`default_nettype wire

// ### testbench/oscillator_source_select_tb.sv
// self-checking bench for the oscillator source select block
// assumes oss_osc_model as the crystal, clock and pll on the far side
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_select_tb;
    import oss_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    localparam logic [7:0] DEC_TAB [25] = '{8'hE1, 8'hEA, 8'hE3, 8'hE5,
        8'hE6, 8'hE7, 8'hED, 8'hEE, 8'hEF, 8'hF1, 8'hF2, 8'hF3, 8'hF5,
        8'hF6, 8'hF7, 8'h60, 8'h62, 8'h64, 8'h68, 8'h69, 8'h6B, 8'h6C,
        8'h0B, 8'h2C, 8'h44};
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] grp = 3'h0;
    logic [4:0] pr = 5'h00;
    logic wake = 1'b0, run = 1'b0, lreq = 1'b0;
    logic power_up_timer = 1'b0, fse = 1'b0, wde = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0;
    logic tick, locked, src_frc, startup_timer, rel, in_gpio, wen, wsys;
    logic frc_en, low_power_rc, lock;
    logic [15:0] rdata;
    logic [2:0] cur, nxt;
    logic [1:0] mul, div, role;
    logic [3:0] tune;
    int num_errors = 0;
    int checks = 0;
    int nticks = 0;
    // clock, and the oscillator edges the design has seen
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) nticks <= resetn_i ? nticks + int'(tick) : 0;
    oss_osc_model osc (.clk_i(clk_sys_i), .run_i(run), .lock_req_i(lreq),
        .tick_o(tick), .locked_o(locked));
    oss_source_select dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .group_select_i(grp), .primary_select_i(pr), .wake_i(wake),
        .osc_tick_i(tick), .pll_locked_i(locked), .power_up_timer_expired_i(power_up_timer),
        .fail_safe_en_i(fse), .watchdog_en_i(wde), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .current_group_o(cur), .new_group_o(nxt), .pll_mul_o(mul),
        .pll_src_frc_o(src_frc), .pre_div_o(div), .ost_used_o(startup_timer),
        .clk_release_o(rel), .osc_out_role_o(role),
        .osc_in_is_gpio_o(in_gpio), .watch_osc_en_o(wen),
        .watch_is_sysclk_o(wsys), .frc_en_o(frc_en), .frc_tune_o(tune),
        .low_power_rc_en_o(low_power_rc), .lock_o(lock));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic results;
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic do_reset(input logic [2:0] g, input logic [4:0] p,
                            input int n);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        grp <= g;
        pr <= p;
        run <= 1'b0;
        lreq <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        chk({14'h0, low_power_rc, rel}, 16'h0002, "reset state");
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask : do_reset
    // bounded wait for release, then the tick count it took
    task automatic wait_rel(input int lo, input int hi);
        int base;
        int i;
        base = nticks;
        for (i = 0; i < 4000 && rel !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk({14'h0, rel, nticks - base >= lo && nticks - base <= hi},
            16'h0003, "start count");
    endtask : wait_rel
    task automatic pulse_wake;
        @(posedge clk_sys_i);
        wake <= 1'b1;
        @(posedge clk_sys_i);
        wake <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask : pulse_wake
    // expected {mul, frc source, pre-divide, start timer, pin role}
    function automatic logic [7:0] exp_dec(input logic [2:0] g,
                                           input logic [4:0] p);
        logic x;
        logic pll;
        logic [1:0] r;
        x = p inside {5'h00, 5'h02, 5'h04, 5'h05, 5'h06, 5'h07, 5'h11,
                      5'h12, 5'h13, 5'h15, 5'h16, 5'h17};
        pll = (g == OSS_GRP_PLL);
        r = x ? OSS_PIN_XTAL : (p inside {OSS_PR_ERC, OSS_PR_EC}) ?
            OSS_PIN_CLOCK_OUTPUT : OSS_PIN_GPIO;
        return {pll ? p[1:0] : 2'h0,
                pll && (p inside {OSS_PR_FRC4, OSS_PR_FRC8, OSS_PR_FRC16}),
                (pll && p[4]) ? (p[2] ? 2'h3 : 2'h2) : 2'h1,
                (g == OSS_GRP_WATCH) || (x && g inside {3'h7, 3'h3}), r};
    endfunction : exp_dec
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_decode;
        logic [2:0] g;
        logic [4:0] p;
        logic [7:0] e;
        logic [15:0] d;
        foreach (DEC_TAB[i]) begin
            g = DEC_TAB[i][7:5];
            p = DEC_TAB[i][4:0];
            e = exp_dec(g, p);
            do_reset(g, p, 2);
            if (g inside {OSS_GRP_PLL, OSS_GRP_EXT}) begin
                chk({8'h0, mul, src_frc, div, startup_timer, role}, {8'h0, e},
                    "primary decode");
            end else begin
                chk({13'h0, startup_timer, role}, {13'h0, e[2:0]}, "side");
            end
            chk({7'h0, cur, 1'b0, nxt, 1'b0, in_gpio},
                {7'h0, g, 1'b0, g, 2'h0}, "groups");
            if (g != OSS_GRP_PLL) begin
                chk({15'h0, frc_en}, {15'h0, g == OSS_GRP_FRC}, "frc");
            end
            rd_reg(2'h0, d);
            chk(d, {1'b0, g, 1'b0, g, 8'h00}, "ctrl read");
            @(posedge clk_sys_i);
            grp <= ~g;
            pr <= ~p;
            repeat (2) @(posedge clk_sys_i);
            #1 chk({11'h0, cur, role}, {11'h0, g, e[1:0]}, "hold");
        end
    endtask : t_decode
    task automatic t_ost;
        logic [15:0] d;
        // crystal: held for the full count, and again after wake
        do_reset(OSS_GRP_EXT, OSS_PR_MIDXT, 2);
        chk({15'h0, rel}, 16'h0000, "held");
        @(posedge clk_sys_i);
        run <= 1'b1;
        wait_rel(1024, 1025);
        pulse_wake();
        chk({15'h0, rel}, 16'h0000, "wake held");
        wait_rel(1022, 1025);
        // pll crystal mode also waits for lock
        do_reset(OSS_GRP_PLL, 5'h11, 2);
        @(posedge clk_sys_i);
        run <= 1'b1;
        repeat (2100) @(posedge clk_sys_i);
        #1 chk({14'h0, rel, lock}, 16'h0000, "no lock");
        @(posedge clk_sys_i);
        lreq <= 1'b1;
        wait_rel(0, 99999);
        rd_reg(2'h0, d);
        chk({14'h0, d[5], lock}, 16'h0003, "locked");
        @(posedge clk_sys_i);
        lreq <= 1'b0;
        rd_reg(2'h0, d);
        rd_reg(2'h0, d);
        chk({14'h0, d[5], lock}, 16'h0000, "lock lost");
        // external clock: no wait, wake leaves it running
        do_reset(OSS_GRP_EXT, OSS_PR_EC, 2);
        chk({15'h0, rel}, 16'h0001, "ec free");
        pulse_wake();
        chk({15'h0, rel}, 16'h0001, "ec wake");
    endtask : t_ost
    task automatic t_regs;
        logic [15:0] d;
        do_reset(OSS_GRP_WATCH, OSS_PR_LFXT, 2);
        chk({14'h0, wen, wsys}, 16'h0000, "watch off");
        wr_reg(2'h0, 16'h7102);
        #1 chk({14'h0, wen, wsys}, 16'h0003, "watch on");
        rd_reg(2'h0, d);
        chk(d, 16'h0102, "ctrl");
        wr_reg(2'h0, 16'h0100);
        #1 chk({15'h0, wsys}, 16'h0000, "watch idle");
        // no x16 fast rc here, so every tune code is legal
        for (int i = 0; i < 16; i++) begin
            wr_reg(2'h1, {12'hFFF, i[3:0]});
            rd_reg(2'h1, d);
            chk(d, {12'h0, i[3:0]}, "tune read");
            chk({12'h0, tune}, {12'h0, i[3:0]}, "tune out");
        end
        wr_reg(2'h2, 16'hFFFF);
        rd_reg(2'h2, d);
        chk(d, 16'h0000, "unmapped");
        rd_reg(2'h0, d);
        chk(d, 16'h0100, "ctrl kept");
        @(posedge clk_sys_i);
        #1 chk(rdata, 16'h0000, "idle data");
    endtask : t_regs
    task automatic set_lp(input logic f, input logic w, input logic e);
        @(posedge clk_sys_i);
        fse <= f;
        wde <= w;
        power_up_timer <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 chk({15'h0, low_power_rc}, {15'h0, e}, "low_power_rc");
    endtask : set_lp
    task automatic t_low_power_rc;
        do_reset(OSS_GRP_EXT, OSS_PR_EC, 2);
        chk({15'h0, low_power_rc}, 16'h0001, "low_power_rc early");
        set_lp(1'b0, 1'b0, 1'b0);
        set_lp(1'b1, 1'b0, 1'b1);
        set_lp(1'b0, 1'b1, 1'b1);
        set_lp(1'b0, 1'b0, 1'b0);
        do_reset(OSS_GRP_LOW_POWER_RC, OSS_PR_EC, 2);
        set_lp(1'b0, 1'b0, 1'b1);
    endtask : t_low_power_rc
    // main sequence
    initial begin
        do_reset(OSS_GRP_EXT, OSS_PR_EC, 16);
        t_decode();
        t_ost();
        t_regs();
        t_low_power_rc();
        results();
    end
    // the whole run needs well under 20000 cycles
    initial begin
        #400000;
        num_errors++;
        results();
    end
endmodule : oscillator_source_select_tb
`default_nettype wire

// ### testbench/oss_osc_model.sv
// far-side oscillator model: one tick per oscillator cycle, pll lock
// assumes the bench raises run_i only while the oscillator swings
`timescale 1ns/100ps
`default_nettype none
module oss_osc_model #(
    parameter int DIV = 2,
    parameter int LOCK_DLY = 40
) (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic lock_req_i,
    output logic tick_o,
    output logic locked_o
);
    int div_q = 0;
    int lock_q = 0;
    // ****************************************
    // oscillator and loop
    // ****************************************
    // a stopped oscillator makes no edges, so the tick stays low
    always @(posedge clk_i) begin
        div_q <= run_i ? (div_q + 1) % DIV : 0;
        tick_o <= run_i && (div_q == DIV - 1);
    end
    // the loop needs time to settle; losing the request drops lock at once
    always @(posedge clk_i) begin
        lock_q <= lock_req_i ? lock_q + 1 : 0;
        locked_o <= lock_req_i && (lock_q >= LOCK_DLY);
    end
endmodule : oss_osc_model
`default_nettype wire
